// ===== pca_chop_accum.sv
// Pulse combining and sample averaging for two time slots.
// Assumes the ADC delivers one result per cycle at most, tagged with
// its slot, and that software writes registers on the same clock.
`timescale 1ns/100ps
`default_nettype none

`include "pca_regs.svh"

module pca_chop_accum
    import pca_pkg::*;
(
    input  wire logic      mclk_in,
    input  wire logic      resetn_in,
    input  wire logic      reg_wr_en_in,
    input  wire logic      reg_rd_en_in,
    input  wire pca_addr_t reg_addr_in,
    input  wire pca_word_t reg_wdata_in,
    output pca_word_t      reg_rdata_out,
    input  wire logic      pulse_valid_in,
    output logic           pulse_ready_out,
    input  wire pca_slot_e pulse_slot_in,
    input  wire pca_adc_t  pulse_data_in,
    output logic           slot_a_integ_invert_out,
    output logic           slot_b_integ_invert_out,
    output logic           bias_enable_out,
    output logic [1:0]     slot_a_bias_out,
    output logic [1:0]     slot_b_bias_out,
    output logic           out_valid_out,
    input  wire logic      out_ready_in,
    output pca_slot_e      out_slot_out,
    output pca_acc_t       out_data_out
);

    pca_word_t   samp_freq_reg, samp_freq_next;
    pca_word_t   avg_count_reg, avg_count_next;
    pca_word_t   a_chop_reg, a_chop_next;
    pca_word_t   a_ofs_first_reg, a_ofs_first_next;
    pca_word_t   a_ofs_last_reg, a_ofs_last_next;
    pca_word_t   b_chop_reg, b_chop_next;
    pca_word_t   b_ofs_first_reg, b_ofs_first_next;
    pca_word_t   b_ofs_last_reg, b_ofs_last_next;
    pca_word_t   a_timing_reg, a_timing_next;
    pca_word_t   b_timing_reg, b_timing_next;
    pca_word_t   bias_reg, bias_next;
    pca_word_t   math_reg, math_next;
    pca_word_t   rdata_reg, rdata_next;

    logic [7:0]  pidx_reg [2];
    logic [7:0]  pidx_next [2];
    logic [7:0]  scnt_reg [2];
    logic [7:0]  scnt_next [2];
    pca_acc_t    acc_reg [2];
    pca_acc_t    acc_next [2];
    pca_acc_t    sum_reg [2];
    pca_acc_t    sum_next [2];

    logic [7:0]  pc_eff [2];
    logic [7:0]  navg [2];
    logic [3:0]  pattern [2];
    logic [1:0]  pair1 [2];
    logic [1:0]  pair2 [2];
    logic        subtract [2];
    logic        pulse_last [2];
    logic        samp_last [2];
    logic        hit;
    logic        fifo_ready;
    logic        push_valid;
    pca_slot_e   push_slot;
    pca_acc_t    push_data;
    pca_acc_t    term;
    pca_acc_t    acc_sum;
    logic [32:0] fifo_out;

    // Register writes and registered read data; unmapped reads give zero
    always_comb
    begin
        samp_freq_next   = samp_freq_reg;
        avg_count_next   = avg_count_reg;
        a_chop_next      = a_chop_reg;
        a_ofs_first_next = a_ofs_first_reg;
        a_ofs_last_next  = a_ofs_last_reg;
        b_chop_next      = b_chop_reg;
        b_ofs_first_next = b_ofs_first_reg;
        b_ofs_last_next  = b_ofs_last_reg;
        a_timing_next    = a_timing_reg;
        b_timing_next    = b_timing_reg;
        bias_next        = bias_reg;
        math_next        = math_reg;
        rdata_next       = rdata_reg;
        if (reg_wr_en_in)
        begin
            if (reg_addr_in == `PCA_ADDR_SAMPLE_FREQ)
                samp_freq_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_AVG_COUNT)
                avg_count_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_A_CHOP)
                a_chop_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_A_OFS_FIRST)
                a_ofs_first_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_A_OFS_LAST)
                a_ofs_last_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_B_CHOP)
                b_chop_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_B_OFS_FIRST)
                b_ofs_first_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_B_OFS_LAST)
                b_ofs_last_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_A_TIMING)
                a_timing_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_B_TIMING)
                b_timing_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_BIAS)
                bias_next = reg_wdata_in;
            else if (reg_addr_in == `PCA_ADDR_MATH)
                math_next = reg_wdata_in;
        end
        if (reg_rd_en_in)
        begin
            if (reg_addr_in == `PCA_ADDR_SAMPLE_FREQ)
                rdata_next = samp_freq_reg;
            else if (reg_addr_in == `PCA_ADDR_AVG_COUNT)
                rdata_next = avg_count_reg;
            else if (reg_addr_in == `PCA_ADDR_A_CHOP)
                rdata_next = a_chop_reg;
            else if (reg_addr_in == `PCA_ADDR_A_OFS_FIRST)
                rdata_next = a_ofs_first_reg;
            else if (reg_addr_in == `PCA_ADDR_A_OFS_LAST)
                rdata_next = a_ofs_last_reg;
            else if (reg_addr_in == `PCA_ADDR_B_CHOP)
                rdata_next = b_chop_reg;
            else if (reg_addr_in == `PCA_ADDR_B_OFS_FIRST)
                rdata_next = b_ofs_first_reg;
            else if (reg_addr_in == `PCA_ADDR_B_OFS_LAST)
                rdata_next = b_ofs_last_reg;
            else if (reg_addr_in == `PCA_ADDR_A_TIMING)
                rdata_next = a_timing_reg;
            else if (reg_addr_in == `PCA_ADDR_B_TIMING)
                rdata_next = b_timing_reg;
            else if (reg_addr_in == `PCA_ADDR_BIAS)
                rdata_next = bias_reg;
            else if (reg_addr_in == `PCA_ADDR_MATH)
                rdata_next = math_reg;
            else
                rdata_next = 16'h0000;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            samp_freq_reg   <= `PCA_REG_RESET;
            avg_count_reg   <= `PCA_REG_RESET;
            a_chop_reg      <= `PCA_REG_RESET;
            a_ofs_first_reg <= `PCA_REG_RESET;
            a_ofs_last_reg  <= `PCA_REG_RESET;
            b_chop_reg      <= `PCA_REG_RESET;
            b_ofs_first_reg <= `PCA_REG_RESET;
            b_ofs_last_reg  <= `PCA_REG_RESET;
            a_timing_reg    <= `PCA_REG_RESET;
            b_timing_reg    <= `PCA_REG_RESET;
            bias_reg        <= `PCA_REG_RESET;
            math_reg        <= `PCA_REG_RESET;
            rdata_reg       <= `PCA_REG_RESET;
        end
        else
        begin
            samp_freq_reg   <= samp_freq_next;
            avg_count_reg   <= avg_count_next;
            a_chop_reg      <= a_chop_next;
            a_ofs_first_reg <= a_ofs_first_next;
            a_ofs_last_reg  <= a_ofs_last_next;
            b_chop_reg      <= b_chop_next;
            b_ofs_first_reg <= b_ofs_first_next;
            b_ofs_last_reg  <= b_ofs_last_next;
            a_timing_reg    <= a_timing_next;
            b_timing_reg    <= b_timing_next;
            bias_reg        <= bias_next;
            math_reg        <= math_next;
            rdata_reg       <= rdata_next;
        end
    end

    assign reg_rdata_out = rdata_reg;

    // Bias settings go to the analog side as plain levels
    assign bias_enable_out = bias_reg[`PCA_BIAS_EN_BIT];
    assign slot_a_bias_out = bias_reg[`PCA_BIAS_A_MSB:`PCA_BIAS_A_LSB];
    assign slot_b_bias_out = bias_reg[`PCA_BIAS_B_MSB:`PCA_BIAS_B_LSB];

    // Field extraction; a pulse count of zero is run as one pulse
    assign pc_eff[0]  = (a_timing_reg[`PCA_PULSE_CNT_MSB:`PCA_PULSE_CNT_LSB]
                         == 8'h00) ? 8'h01
                        : a_timing_reg[`PCA_PULSE_CNT_MSB:`PCA_PULSE_CNT_LSB];
    assign pc_eff[1]  = (b_timing_reg[`PCA_PULSE_CNT_MSB:`PCA_PULSE_CNT_LSB]
                         == 8'h00) ? 8'h01
                        : b_timing_reg[`PCA_PULSE_CNT_MSB:`PCA_PULSE_CNT_LSB];
    assign navg[0]    = 8'h01 << avg_count_reg[`PCA_AVG_A_MSB:`PCA_AVG_A_LSB];
    assign navg[1]    = 8'h01 << avg_count_reg[`PCA_AVG_B_MSB:`PCA_AVG_B_LSB];
    assign pattern[0] = a_chop_reg[`PCA_CHOP_MSB:`PCA_CHOP_LSB];
    assign pattern[1] = b_chop_reg[`PCA_CHOP_MSB:`PCA_CHOP_LSB];
    assign pair1[0]   = math_reg[`PCA_PAIR1_A_MSB:`PCA_PAIR1_A_LSB];
    assign pair1[1]   = math_reg[`PCA_PAIR1_B_MSB:`PCA_PAIR1_B_LSB];
    assign pair2[0]   = math_reg[`PCA_PAIR2_A_MSB:`PCA_PAIR2_A_LSB];
    assign pair2[1]   = math_reg[`PCA_PAIR2_B_MSB:`PCA_PAIR2_B_LSB];

    // Polarity the AFE must use for each slot's coming pulse
    assign slot_a_integ_invert_out = pattern[0][pidx_reg[0][1:0]];
    assign slot_b_integ_invert_out = pattern[1][pidx_reg[1][1:0]];

    // Pulses stall while the FIFO is full, so a finished sample never drops
    assign pulse_ready_out = fifo_ready;
    assign hit             = pulse_valid_in && fifo_ready;
    assign term            = pca_acc_t'({18'h00000, pulse_data_in});

    // Per-pulse sign, pulse and sample counting, accumulation, averaging
    always_comb
    begin
        push_valid = 1'b0;
        push_slot  = PCA_SLOT_A;
        push_data  = '0;
        acc_sum    = '0;
        for (int s = 0; s < 2; s++)
        begin
            // Odd pulse of a pair reads the high bit, even the low bit
            subtract[s]   = pidx_reg[s][1] ?
                            pair2[s][~pidx_reg[s][0]] :
                            pair1[s][~pidx_reg[s][0]];
            pulse_last[s] = ({1'b0, pidx_reg[s]} + 9'h001)
                            == {1'b0, pc_eff[s]};
            samp_last[s]  = ({1'b0, scnt_reg[s]} + 9'h001)
                            == {1'b0, navg[s]};
            pidx_next[s]  = pidx_reg[s];
            scnt_next[s]  = scnt_reg[s];
            acc_next[s]   = acc_reg[s];
            sum_next[s]   = sum_reg[s];
            if (hit && (pulse_slot_in == pca_slot_e'(s)))
            begin
                // Signed arithmetic keeps a running difference from wrapping
                acc_sum = subtract[s] ? acc_reg[s] - term
                                      : acc_reg[s] + term;
                if (pulse_last[s])
                begin
                    pidx_next[s] = 8'h00;
                    acc_next[s]  = '0;
                    if (samp_last[s])
                    begin
                        // Output once per navg internal samples
                        push_valid   = 1'b1;
                        push_slot    = pca_slot_e'(s);
                        push_data    = sum_reg[s] + acc_sum;
                        sum_next[s]  = '0;
                        scnt_next[s] = 8'h00;
                    end
                    else
                    begin
                        sum_next[s]  = sum_reg[s] + acc_sum;
                        scnt_next[s] = scnt_reg[s] + 8'h01;
                    end
                end
                else
                begin
                    pidx_next[s] = pidx_reg[s] + 8'h01;
                    acc_next[s]  = acc_sum;
                end
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        for (int s = 0; s < 2; s++)
        begin
            if (!resetn_in)
            begin
                pidx_reg[s] <= 8'h00;
                scnt_reg[s] <= 8'h00;
                acc_reg[s]  <= '0;
                sum_reg[s]  <= '0;
            end
            else
            begin
                pidx_reg[s] <= pidx_next[s];
                scnt_reg[s] <= scnt_next[s];
                acc_reg[s]  <= acc_next[s];
                sum_reg[s]  <= sum_next[s];
            end
        end
    end

    // Finished samples queue here until the reader takes them
    pca_fifo #(
        .WIDTH (33),
        .DEPTH (`PCA_FIFO_DEPTH)
    ) u_fifo (
        .mclk_in       (mclk_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (push_valid),
        .in_ready_out  (fifo_ready),
        .in_data_in    ({push_slot, push_data}),
        .out_valid_out (out_valid_out),
        .out_ready_in  (out_ready_in),
        .out_data_out  (fifo_out)
    );

    assign out_slot_out = pca_slot_e'(fifo_out[32]);
    assign out_data_out = fifo_out[31:0];

    // Helper: slot A pulses taken since its last output word or non-bias register write
    logic [15:0] a_eff_cnt;
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in || (reg_wr_en_in && reg_addr_in != `PCA_ADDR_BIAS))
            a_eff_cnt <= 16'h0000;
        else if (push_valid && push_slot == PCA_SLOT_A)
            a_eff_cnt <= 16'h0000;
        else if (hit && pulse_slot_in == PCA_SLOT_A)
            a_eff_cnt <= a_eff_cnt + 16'h0001;
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_last_a;
        hit && pulse_slot_in == PCA_SLOT_A && pulse_last[0];
    endsequence

    sequence s_mid_a;
        hit && pulse_slot_in == PCA_SLOT_A && !pulse_last[0];
    endsequence

    a_pulse_wrap: assert property (
        s_last_a |=> pidx_reg[0] == 8'h00)
        else $error("slot A pulse index did not wrap at pulse count");
    a_push_at_avg: assert property (
        push_valid |-> (push_slot == PCA_SLOT_A
        ? samp_last[0] && pulse_last[0] : samp_last[1] && pulse_last[1]))
        else $error("output pushed before averaging count reached");
    a_eff_pulses: assert property (
        push_valid && push_slot == PCA_SLOT_A && !reg_wr_en_in
        |-> a_eff_cnt + 16'h0001 == 16'(pc_eff[0]) * 16'(navg[0]))
        else $error("pulses per output sample differ from count times avg");
    a_rate_div: assert property (
        s_last_a |-> push_valid == samp_last[0])
        else $error("output not tied to the final internal sample");
    a_bias_enable: assert property (
        reg_wr_en_in && reg_addr_in == `PCA_ADDR_BIAS
        |=> bias_enable_out == $past(reg_wdata_in[`PCA_BIAS_EN_BIT]))
        else $error("bias enable does not follow register write");
    a_bias_level: assert property (
        reg_wr_en_in && reg_addr_in == `PCA_ADDR_BIAS
        |=> slot_a_bias_out == $past(reg_wdata_in[9:8])
        && slot_b_bias_out == $past(reg_wdata_in[11:10]))
        else $error("bias level fields mismatch");
    a_chop_polarity: assert property (
        (s_mid_a and !reg_wr_en_in)
        |=> slot_a_integ_invert_out ==
        pattern[0][$past(pidx_reg[0][1:0]) + 2'b01])
        else $error("integrator polarity not from pattern bit");
    a_pulse_sign: assert property (
        s_mid_a |=> acc_reg[0] ==
        ($past(subtract[0]) ? $past(acc_reg[0]) - $past(term)
        : $past(acc_reg[0]) + $past(term)))
        else $error("pulse result added or subtracted wrongly");
    a_pair_decode: assert property (
        hit && pidx_reg[0][1:0] == 2'b01 && pulse_slot_in == PCA_SLOT_A
        |-> subtract[0] == pair1[0][0])
        else $error("second pulse sign not from low bit of pair field");
    a_pair2_decode: assert property (
        hit && pidx_reg[0][1:0] == 2'b10 && pulse_slot_in == PCA_SLOT_A
        |-> subtract[0] == pair2[0][1])
        else $error("third pulse sign not from high bit of pair field");

endmodule

`default_nettype wire

// ===== pca_regs.svh
// Register offsets, field positions, reset values and counts for the
// pulse chop accumulator.
// Assumes inclusion by bare name from any file that needs the map.
`ifndef PCA_REGS_SVH
`define PCA_REGS_SVH

// Register offsets on the register port
`define PCA_ADDR_SAMPLE_FREQ   8'h12
`define PCA_ADDR_AVG_COUNT     8'h15
`define PCA_ADDR_A_CHOP        8'h17
`define PCA_ADDR_A_OFS_FIRST   8'h18
`define PCA_ADDR_A_OFS_LAST    8'h1B
`define PCA_ADDR_B_CHOP        8'h1D
`define PCA_ADDR_B_OFS_FIRST   8'h1E
`define PCA_ADDR_B_OFS_LAST    8'h21
`define PCA_ADDR_A_TIMING      8'h31
`define PCA_ADDR_B_TIMING      8'h36
`define PCA_ADDR_BIAS          8'h54
`define PCA_ADDR_MATH          8'h58

// Field positions
`define PCA_PULSE_CNT_MSB      15
`define PCA_PULSE_CNT_LSB      8
`define PCA_AVG_A_MSB          6
`define PCA_AVG_A_LSB          4
`define PCA_AVG_B_MSB          10
`define PCA_AVG_B_LSB          8
`define PCA_CHOP_MSB           3
`define PCA_CHOP_LSB           0
`define PCA_BIAS_EN_BIT        7
`define PCA_BIAS_B_MSB         11
`define PCA_BIAS_B_LSB         10
`define PCA_BIAS_A_MSB         9
`define PCA_BIAS_A_LSB         8
`define PCA_PAIR2_B_MSB        11
`define PCA_PAIR2_B_LSB        10
`define PCA_PAIR2_A_MSB        9
`define PCA_PAIR2_A_LSB        8
`define PCA_PAIR1_B_MSB        6
`define PCA_PAIR1_B_LSB        5
`define PCA_PAIR1_A_MSB        2
`define PCA_PAIR1_A_LSB        1

// Reset value of every register
`define PCA_REG_RESET          16'h0000

// Output FIFO depth in words
`define PCA_FIFO_DEPTH         16

`endif

// ===== pca_pkg.sv
// Types shared by the pulse chop accumulator files.
// Assumes compilation before any module that imports it.
package pca_pkg;

    typedef logic [15:0]        pca_word_t;
    typedef logic [13:0]        pca_adc_t;
    typedef logic signed [31:0] pca_acc_t;
    typedef logic [7:0]         pca_addr_t;

    // Time slot carried with each pulse and each output word
    typedef enum logic { PCA_SLOT_A, PCA_SLOT_B } pca_slot_e;

endpackage

// ===== pca_fifo.sv
// Output FIFO holding finished samples with their slot tag.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module pca_fifo
#(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
)
(
    input  wire logic             mclk_in,
    input  wire logic             resetn_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    wptr_next;
    logic [AW-1:0]    rptr_reg;
    logic [AW-1:0]    rptr_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    // Honest full and empty come straight from the fill count
    assign in_ready_out  = (count_reg != DEPTH[AW:0]);
    assign out_valid_out = (count_reg != '0);
    assign out_data_out  = mem_reg[rptr_reg];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Pointer and count update
    always_comb
    begin
        wptr_next  = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next  = pop ? rptr_reg + 1'b1 : rptr_reg;
        count_next = count_reg;
        if (push && !pop)
        begin
            count_next = count_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end
        else
        begin
            wptr_reg  <= wptr_next;
            rptr_reg  <= rptr_next;
            count_reg <= count_next;
        end
    end

    // Storage needs no reset; only words below the count are read
    always_ff @(posedge mclk_in)
    begin
        if (push)
        begin
            mem_reg[wptr_reg] <= in_data_in;
        end
    end

endmodule

`default_nettype wire

// ===== pca_adc_model.sv
// Front end model: hands one ADC result at a time to the block.
// Assumes one calling process; a result is never dropped.
`timescale 1ns/100ps
`default_nettype none
module pca_adc_model
    import pca_pkg::*;
(
    input  wire logic     mclk_in,
    input  wire logic     ready_in,
    output var logic      valid_out = 1'b0,
    output var pca_slot_e slot_out = PCA_SLOT_A,
    output var pca_adc_t  data_out = 14'h0000
);
    // Result stands until the edge that takes it
    task automatic send(input pca_slot_e s, input pca_adc_t d);
        @(negedge mclk_in);
        valid_out = 1'b1;
        slot_out = s;
        data_out = d;
        @(posedge mclk_in);
        while (ready_in !== 1'b1)
            @(posedge mclk_in);
    endtask
    // Released bus shows inverted data, so a stale copy cannot match
    task automatic idle();
        @(negedge mclk_in);
        valid_out = 1'b0;
        data_out = ~data_out;
    endtask
endmodule
`default_nettype wire

// ===== test_pulse_chop_accumulator.sv
// Bench: register port, pulse combining, averaging and output FIFO.
// Assumes the design files and the front end model compile first.
`timescale 1ns/100ps
`default_nettype none
`include "pca_regs.svh"
module test_pulse_chop_accumulator
    import pca_pkg::*;
;
    logic       mclk_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic       o_ready = 1'b0;
    pca_addr_t  addr = 8'h00;
    pca_word_t  wdata = 16'h0000;
    pca_word_t  rdata;
    logic       p_valid, p_ready, inv_a, inv_b, bias_en, o_valid;
    logic [1:0] bias_a, bias_b;
    pca_slot_e  p_slot, o_slot;
    pca_adc_t   p_data;
    pca_acc_t   o_data;
    pca_adc_t   va [8] = '{10, 3, 20, 5, 7, 1, 2, 9};
    int         bad_count = 0, checks = 0, cycles = 0;
    always #50 mclk_in = ~mclk_in;
    pca_chop_accum DUT (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .pulse_valid_in(p_valid), .pulse_ready_out(p_ready),
        .pulse_slot_in(p_slot), .pulse_data_in(p_data),
        .slot_a_integ_invert_out(inv_a), .slot_b_integ_invert_out(inv_b),
        .bias_enable_out(bias_en), .slot_a_bias_out(bias_a),
        .slot_b_bias_out(bias_b), .out_valid_out(o_valid),
        .out_ready_in(o_ready), .out_slot_out(o_slot),
        .out_data_out(o_data));
    pca_adc_model adc (.mclk_in(mclk_in), .ready_in(p_ready),
        .valid_out(p_valid), .slot_out(p_slot), .data_out(p_data));
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Sums are the widest result; other kinds widen into it
    task automatic cmp_a(input pca_acc_t g, input pca_acc_t e);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_w(input pca_word_t g, input pca_word_t e);
        cmp_a({16'h0000, g}, {16'h0000, e});
    endtask
    task automatic cmp_c(input logic [3:0] g, input logic [3:0] e);
        cmp_a({28'h0000000, g}, {28'h0000000, e});
    endtask
    // Hang guard, well above the expected run of about 150 cycles
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            summarize();
        end
    end
    task automatic wr(input pca_addr_t a, input pca_word_t d);
        @(negedge mclk_in);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge mclk_in);
        wr_en = 1'b0;
    endtask
    task automatic rd(input pca_addr_t a, input pca_word_t e);
        @(negedge mclk_in);
        rd_en = 1'b1;
        addr = a;
        @(negedge mclk_in);
        rd_en = 1'b0;
        cmp_w(rdata, e);
    endtask
    // Waits a bounded time for the head word, checks it, pops it
    task automatic pop(input pca_slot_e s, input pca_acc_t e);
        int n = 0;
        @(negedge mclk_in);
        while (o_valid !== 1'b1 && n < 50)
        begin
            @(negedge mclk_in);
            n++;
        end
        cmp_c({3'b000, o_valid}, 4'h1);
        cmp_c({3'b000, o_slot}, {3'b000, s});
        cmp_a(o_data, e);
        o_ready = 1'b1;
        @(negedge mclk_in);
        o_ready = 1'b0;
    endtask
    initial
    begin
        repeat (4) @(negedge mclk_in);
        resetn_in = 1'b1;
        rd(`PCA_ADDR_MATH, `PCA_REG_RESET);
        wr(8'h40, 16'hFFFF);
        rd(8'h40, 16'h0000);
        wr(`PCA_ADDR_BIAS, 16'h0680);
        cmp_c({1'b0, bias_en, bias_b}, 4'h5);
        cmp_c({2'b00, bias_a}, 4'h2);
        rd(`PCA_ADDR_BIAS, 16'h0680);
        wr(`PCA_ADDR_SAMPLE_FREQ, 16'h0190);
        rd(`PCA_ADDR_SAMPLE_FREQ, 16'h0190);
        // Slot A: eight chopped pulses, pattern repeats every four
        wr(`PCA_ADDR_A_OFS_FIRST, 16'h0000);
        wr(`PCA_ADDR_A_CHOP, 16'h000A);
        wr(`PCA_ADDR_MATH, 16'h0102);
        wr(`PCA_ADDR_A_TIMING, 16'h0800);
        for (int k = 0; k < 8; k++)
        begin
            cmp_c(4'(inv_a), (4'hA >> k % 4) & 4'h1);
            adc.send(PCA_SLOT_A, va[k]);
            #1;
        end
        adc.idle();
        pop(PCA_SLOT_A, 32'sd21);
        // Slot B: every pair code, two samples of four summed
        wr(`PCA_ADDR_B_CHOP, 16'h0005);
        wr(`PCA_ADDR_B_TIMING, 16'h0400);
        wr(`PCA_ADDR_AVG_COUNT, 16'h0100);
        for (int c = 0; c < 4; c++)
        begin
            wr(`PCA_ADDR_MATH, 16'((c << 5) | (c << 10)));
            cmp_c({3'b000, inv_b}, 4'h1);
            for (int k = 0; k < 8; k++)
            begin
                adc.send(PCA_SLOT_B, pca_adc_t'(1 << (k % 4)));
                #1;
                if (k == 4)
                    cmp_c({3'b000, o_valid}, 4'h0);
            end
            adc.idle();
            pop(PCA_SLOT_B, 2 * ((c & 2) ? -5 : 5)
                + 2 * ((c & 1) ? -10 : 10));
        end
        // Fill the FIFO until it refuses, then drain it in order
        wr(`PCA_ADDR_MATH, 16'h0000);
        wr(`PCA_ADDR_A_TIMING, 16'h0100);
        for (int k = 0; k < 16; k++)
            adc.send(PCA_SLOT_A, pca_adc_t'(k + 1));
        adc.idle();
        repeat (2) @(negedge mclk_in);
        cmp_c({3'b000, p_ready}, 4'h0);
        for (int k = 0; k < 16; k++)
            pop(PCA_SLOT_A, k + 1);
        cmp_c({3'b000, p_ready}, 4'h1);
        // Mid-run reset must clear registers and the levels they drive
        resetn_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        resetn_in = 1'b1;
        cmp_c({1'b0, bias_en, bias_b}, 4'h0);
        cmp_c({3'b000, o_valid}, 4'h0);
        rd(`PCA_ADDR_SAMPLE_FREQ, `PCA_REG_RESET);
        summarize();
    end
endmodule
`default_nettype wire
